// file: rtl/mor_pkg.sv
// Purpose: Constants and types shared by the magnetometer output and status register block.
// Assumes: Byte-wide registers at the printed byte offsets.
// Notes: Write-only registers read back as zero.
package mor_pkg;

   // Register offsets.
   localparam logic [7:0] MOR_ADDR_X_HIGH = 8'h00;
   localparam logic [7:0] MOR_ADDR_X_MID = 8'h01;
   localparam logic [7:0] MOR_ADDR_Y_HIGH = 8'h02;
   localparam logic [7:0] MOR_ADDR_Y_MID = 8'h03;
   localparam logic [7:0] MOR_ADDR_Z_HIGH = 8'h04;
   localparam logic [7:0] MOR_ADDR_Z_MID = 8'h05;
   localparam logic [7:0] MOR_ADDR_X_LOW = 8'h06;
   localparam logic [7:0] MOR_ADDR_Y_LOW = 8'h07;
   localparam logic [7:0] MOR_ADDR_Z_LOW = 8'h08;
   localparam logic [7:0] MOR_ADDR_TEMP = 8'h09;
   localparam logic [7:0] MOR_ADDR_PERIOD_LOW = 8'h0A;
   localparam logic [7:0] MOR_ADDR_PERIOD_HIGH = 8'h0B;
   localparam logic [7:0] MOR_ADDR_TIME_UNIT = 8'h0C;
   localparam logic [7:0] MOR_ADDR_FLAGS = 8'h18;

   // Common command defining bytes.
   localparam logic [7:0] MOR_CCC_PERIOD = 8'h3F;
   localparam logic [7:0] MOR_CCC_TIME_UNIT = 8'h9F;

   // Reset values.
   localparam logic [7:0] MOR_RESET_BYTE = 8'h00;
   localparam logic [19:0] MOR_RESET_FIELD = 20'h00000;
   localparam logic [9:0] MOR_RESET_PERIOD = 10'h000;

   // Measurement flag bit positions.
   localparam int MOR_BIT_MAG_INT = 0;
   localparam int MOR_BIT_TEMP_INT = 1;
   localparam int MOR_BIT_MOTION_INT = 2;
   localparam int MOR_BIT_PARITY_FAIL = 3;
   localparam int MOR_BIT_MEM_LOADED = 4;
   localparam int MOR_BIT_SATURATED = 5;
   localparam int MOR_BIT_MAG_DONE = 6;
   localparam int MOR_BIT_TEMP_DONE = 7;

   // Sync period fields.
   localparam int MOR_BIT_WIDTH_SELECT = 7;
   localparam logic [1:0] MOR_PERIOD_PAD = 2'h0;
   localparam logic MOR_PERIOD_LSB = 1'b0;

   // Resolution masks for the low field bits.
   localparam logic [19:0] MOR_MASK_16BIT = 20'hFFFF0;
   localparam logic [19:0] MOR_MASK_18BIT = 20'hFFFFC;
   localparam logic [19:0] MOR_MASK_20BIT = 20'hFFFFF;
   localparam logic [3:0] MOR_NIBBLE_ZERO = 4'h0;

   // Resolution modes.
   typedef enum logic [1:0] {
      MOR_RES_16 = 2'h0,
      MOR_RES_18 = 2'h1,
      MOR_RES_20 = 2'h2
   } mor_res_t;

   // Kinds of request from the bus engine.
   typedef enum logic [2:0] {
      MOR_REQ_READ = 3'h0,
      MOR_REQ_WRITE = 3'h1,
      MOR_REQ_CCC = 3'h2,
      MOR_REQ_TICK = 3'h3,
      MOR_REQ_PARITY = 3'h4,
      MOR_REQ_IBI = 3'h5
   } mor_req_t;

endpackage

// file: rtl/mor_regs.sv
// Purpose: Output data, sync parameter and measurement flag registers of a 3-axis magnetometer.
// Assumes: The bus engine runs on the link clock; the measurement engine runs on i_ref_clk.
// Notes: Link requests cross by a toggle handshake, one outstanding at a time.
`timescale 1ns/1ps

module mor_regs
   import mor_pkg::*;
(
   // Reference clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // Link side request port from the bus engine.
   input wire logic i_link_clk,
   input wire logic i_req_valid,
   input wire logic [2:0] i_req_kind,
   input wire logic [7:0] i_req_addr,
   input wire logic [7:0] i_req_data,
   input wire logic i_req_i2c,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output logic [7:0] o_rsp_data,
   // Measurement engine events, reference clock domain.
   input wire logic [1:0] i_res_mode,
   input wire logic i_mag_done,
   input wire logic [19:0] i_mag_x,
   input wire logic [19:0] i_mag_y,
   input wire logic [19:0] i_mag_z,
   input wire logic i_temp_done,
   input wire logic [7:0] i_temp,
   input wire logic i_meas_cmd,
   input wire logic i_start_motion,
   input wire logic i_motion,
   input wire logic i_mem_load_start,
   input wire logic i_mem_load_ok,
   input wire logic i_selftest_fail,
   // Sync parameters and notifications, reference clock domain.
   output logic [9:0] o_sync_period,
   output logic [1:0] o_sync_time_unit,
   output logic o_sync_tick,
   output logic o_ibi_request
);

   // Link domain request holding registers.
   logic req_tgl_q;
   logic [2:0] req_kind_q;
   logic [7:0] req_addr_q;
   logic [7:0] req_data_q;
   logic req_i2c_q;
   logic ack_meta_q;
   logic ack_sync_q;
   logic ack_seen_q;
   logic ready_q;
   logic rsp_valid_q;
   logic [7:0] rsp_data_q;

   // Reference domain handshake registers.
   logic req_meta_q;
   logic req_sync_q;
   logic req_seen_q;
   logic ack_tgl_q;
   logic [7:0] read_data_q;

   // Reference domain register contents.
   logic [19:0] x_field_q;
   logic [19:0] y_field_q;
   logic [19:0] z_field_q;
   logic [7:0] temperature_q;
   logic [7:0] sync_period_low_q;
   logic [7:0] sync_period_high_q;
   logic [7:0] sync_time_unit_q;
   logic [7:0] flags_q;
   logic [9:0] sync_period_q;
   logic sync_tick_q;
   logic ibi_request_q;

   // Decoded request in the reference domain.
   logic req_new;
   logic do_read;
   logic do_write;
   logic do_ccc;
   logic mag_access;
   logic temp_access;
   logic flags_read;
   logic mag_read;
   logic temp_read;
   logic ibi_sent;
   logic parity_bad;

   // Returns true for any of the nine magnetic data offsets.
   function automatic logic is_mag_addr(input logic [7:0] addr);
      logic hit;
      hit = (addr >= MOR_ADDR_X_HIGH) && (addr <= MOR_ADDR_Z_LOW);
      return hit;
   endfunction

   // Keeps only the result bits that the resolution mode makes valid.
   function automatic logic [19:0] res_mask(input logic [19:0] value, input logic [1:0] mode);
      logic [19:0] result;
      case (mode)
         MOR_RES_16: result = value & MOR_MASK_16BIT;
         MOR_RES_18: result = value & MOR_MASK_18BIT;
         default: result = value & MOR_MASK_20BIT;
      endcase
      return result;
   endfunction

   // Forms the sync period from the two stored period bytes.
   function automatic logic [9:0] period_of(input logic [7:0] low, input logic [7:0] high);
      logic [9:0] value;
      if (low[MOR_BIT_WIDTH_SELECT]) begin
         value = {high[1:0], low[6:0], MOR_PERIOD_LSB};
      end else begin
         value = {MOR_PERIOD_PAD, low[6:0], MOR_PERIOD_LSB};
      end
      return value;
   endfunction

   // Read multiplexer; write-only and unmapped offsets read as zero.
   function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic [19:0] x,
         input logic [19:0] y, input logic [19:0] z, input logic [7:0] t,
         input logic [7:0] flags);
      logic [7:0] data;
      case (addr)
         MOR_ADDR_X_HIGH: data = x[19:12];
         MOR_ADDR_X_MID: data = x[11:4];
         MOR_ADDR_X_LOW: data = {x[3:0], MOR_NIBBLE_ZERO};
         MOR_ADDR_Y_HIGH: data = y[19:12];
         MOR_ADDR_Y_MID: data = y[11:4];
         MOR_ADDR_Y_LOW: data = {y[3:0], MOR_NIBBLE_ZERO};
         MOR_ADDR_Z_HIGH: data = z[19:12];
         MOR_ADDR_Z_MID: data = z[11:4];
         MOR_ADDR_Z_LOW: data = {z[3:0], MOR_NIBBLE_ZERO};
         MOR_ADDR_TEMP: data = t;
         MOR_ADDR_FLAGS: data = flags;
         default: data = MOR_RESET_BYTE;
      endcase
      return data;
   endfunction

   // Link side: capture one request and hold it stable until the answer returns.
   always_ff @(posedge i_link_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         req_tgl_q <= 1'b0;
         req_kind_q <= MOR_REQ_READ;
         req_addr_q <= MOR_RESET_BYTE;
         req_data_q <= MOR_RESET_BYTE;
         req_i2c_q <= 1'b0;
      end else if (i_req_valid && ready_q) begin
         req_tgl_q <= ~req_tgl_q;
         req_kind_q <= i_req_kind;
         req_addr_q <= i_req_addr;
         req_data_q <= i_req_data;
         req_i2c_q <= i_req_i2c;
      end
   end

   // Link side: synchronise the acknowledge toggle.
   always_ff @(posedge i_link_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ack_meta_q <= 1'b0;
         ack_sync_q <= 1'b0;
         ack_seen_q <= 1'b0;
      end else begin
         ack_meta_q <= ack_tgl_q;
         ack_sync_q <= ack_meta_q;
         ack_seen_q <= ack_sync_q;
      end
   end

   // Link side: ready falls on acceptance and rises again with the answer.
   always_ff @(posedge i_link_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ready_q <= 1'b1;
         rsp_valid_q <= 1'b0;
         rsp_data_q <= MOR_RESET_BYTE;
      end else begin
         rsp_valid_q <= 1'b0;
         if (ack_sync_q != ack_seen_q) begin
            ready_q <= 1'b1;
            rsp_valid_q <= 1'b1;
            rsp_data_q <= read_data_q; // Loaded on the same edge as the toggle; settled before the toggle is seen.
         end else if (i_req_valid && ready_q) begin
            ready_q <= 1'b0;
         end
      end
   end

   // Reference side: synchronise the request toggle.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         req_meta_q <= 1'b0;
         req_sync_q <= 1'b0;
         req_seen_q <= 1'b0;
      end else begin
         req_meta_q <= req_tgl_q;
         req_sync_q <= req_meta_q;
         req_seen_q <= req_sync_q;
      end
   end

   // Decode of the request that has just crossed over.
   assign req_new = req_sync_q != req_seen_q;
   assign do_read = req_new && (req_kind_q == MOR_REQ_READ);
   assign do_write = req_new && (req_kind_q == MOR_REQ_WRITE);
   assign do_ccc = req_new && (req_kind_q == MOR_REQ_CCC);
   assign mag_access = (do_read || do_write) && req_i2c_q && is_mag_addr(req_addr_q);
   assign temp_access = (do_read || do_write) && req_i2c_q && (req_addr_q == MOR_ADDR_TEMP);
   assign flags_read = do_read && (req_addr_q == MOR_ADDR_FLAGS);
   assign mag_read = do_read && is_mag_addr(req_addr_q);
   assign temp_read = do_read && (req_addr_q == MOR_ADDR_TEMP);
   assign ibi_sent = req_new && (req_kind_q == MOR_REQ_IBI);
   assign parity_bad = req_new && (req_kind_q == MOR_REQ_PARITY);

   // Reference side: answer each request once and return the toggle.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ack_tgl_q <= 1'b0;
         read_data_q <= MOR_RESET_BYTE;
      end else if (req_new) begin
         ack_tgl_q <= ~ack_tgl_q;
         if (do_read) begin
            read_data_q <= read_byte(req_addr_q, x_field_q, y_field_q, z_field_q,
               temperature_q, flags_q);
         end else begin
            read_data_q <= MOR_RESET_BYTE;
         end
      end
   end

   // Field results are loaded together at completion so no read mixes two samples.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         x_field_q <= MOR_RESET_FIELD;
         y_field_q <= MOR_RESET_FIELD;
         z_field_q <= MOR_RESET_FIELD;
      end else if (i_mag_done) begin
         x_field_q <= res_mask(i_mag_x, i_res_mode);
         y_field_q <= res_mask(i_mag_y, i_res_mode);
         z_field_q <= res_mask(i_mag_z, i_res_mode);
      end
   end

   // Temperature code is loaded at its own completion.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         temperature_q <= MOR_RESET_BYTE;
      end else if (i_temp_done) begin
         temperature_q <= i_temp;
      end
   end

   // Sync parameter bytes, from register writes or from the two commands.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync_period_low_q <= MOR_RESET_BYTE;
         sync_period_high_q <= MOR_RESET_BYTE;
         sync_time_unit_q <= MOR_RESET_BYTE;
      end else begin
         if ((do_write && (req_addr_q == MOR_ADDR_PERIOD_LOW)) ||
               (do_ccc && (req_addr_q == MOR_CCC_PERIOD))) begin
            sync_period_low_q <= req_data_q;
         end
         if (do_write && (req_addr_q == MOR_ADDR_PERIOD_HIGH)) begin
            sync_period_high_q <= req_data_q;
         end
         if ((do_write && (req_addr_q == MOR_ADDR_TIME_UNIT)) ||
               (do_ccc && (req_addr_q == MOR_CCC_TIME_UNIT))) begin
            sync_time_unit_q <= req_data_q;
         end
      end
   end

   // Period in measurements; the engine divides by the measurement rate for time.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync_period_q <= MOR_RESET_PERIOD;
      end else begin
         sync_period_q <= period_of(sync_period_low_q, sync_period_high_q);
      end
   end

   // One-cycle sync tick marks the reference instant for period and phase.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync_tick_q <= 1'b0;
      end else begin
         sync_tick_q <= req_new && (req_kind_q == MOR_REQ_TICK);
      end
   end

   // Interrupt flags; a set in the same cycle as a clear wins.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flags_q[MOR_BIT_MAG_INT] <= 1'b0;
         flags_q[MOR_BIT_TEMP_INT] <= 1'b0;
         flags_q[MOR_BIT_MOTION_INT] <= 1'b0;
         flags_q[MOR_BIT_PARITY_FAIL] <= 1'b0;
      end else begin
         if (i_mag_done) begin
            flags_q[MOR_BIT_MAG_INT] <= 1'b1;
         end else if (i_meas_cmd || mag_access || ibi_sent || flags_read) begin
            flags_q[MOR_BIT_MAG_INT] <= 1'b0;
         end
         if (i_temp_done) begin
            flags_q[MOR_BIT_TEMP_INT] <= 1'b1;
         end else if (i_meas_cmd || temp_access || ibi_sent || flags_read) begin
            flags_q[MOR_BIT_TEMP_INT] <= 1'b0;
         end
         if (i_motion) begin
            flags_q[MOR_BIT_MOTION_INT] <= 1'b1;
         end else if (i_start_motion || ibi_sent || flags_read) begin
            flags_q[MOR_BIT_MOTION_INT] <= 1'b0;
         end
         if (parity_bad) begin
            flags_q[MOR_BIT_PARITY_FAIL] <= 1'b1;
         end else if (ibi_sent) begin
            flags_q[MOR_BIT_PARITY_FAIL] <= 1'b0;
         end
      end
   end

   // Memory-loaded and saturation indicators.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flags_q[MOR_BIT_MEM_LOADED] <= 1'b0;
         flags_q[MOR_BIT_SATURATED] <= 1'b0;
      end else begin
         if (i_mem_load_ok) begin
            flags_q[MOR_BIT_MEM_LOADED] <= 1'b1;
         end else if (i_mem_load_start) begin
            flags_q[MOR_BIT_MEM_LOADED] <= 1'b0;
         end
         flags_q[MOR_BIT_SATURATED] <= i_selftest_fail;
      end
   end

   // Plain done flags, cleared only by reads of their data.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flags_q[MOR_BIT_MAG_DONE] <= 1'b0;
         flags_q[MOR_BIT_TEMP_DONE] <= 1'b0;
      end else begin
         if (i_mag_done) begin
            flags_q[MOR_BIT_MAG_DONE] <= 1'b1;
         end else if (mag_read) begin
            flags_q[MOR_BIT_MAG_DONE] <= 1'b0;
         end
         if (i_temp_done) begin
            flags_q[MOR_BIT_TEMP_DONE] <= 1'b1;
         end else if (temp_read) begin
            flags_q[MOR_BIT_TEMP_DONE] <= 1'b0;
         end
      end
   end

   // In-band interrupt request while any interrupt flag stands.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ibi_request_q <= 1'b0;
      end else begin
         ibi_request_q <= flags_q[MOR_BIT_MAG_INT] || flags_q[MOR_BIT_TEMP_INT] ||
            flags_q[MOR_BIT_MOTION_INT] || flags_q[MOR_BIT_PARITY_FAIL];
      end
   end

   // Output drive, all from flip-flops.
   assign o_req_ready = ready_q;
   assign o_rsp_valid = rsp_valid_q;
   assign o_rsp_data = rsp_data_q;
   assign o_sync_period = sync_period_q;
   assign o_sync_time_unit = sync_time_unit_q[1:0];
   assign o_sync_tick = sync_tick_q;
   assign o_ibi_request = ibi_request_q;

endmodule

// file: tb/mor_checker.sv
// Purpose: Port checks for the output and status register block.
// Assumes: Active low reset clears both clock domains.
// Notes: Handshake checks use the link clock, event checks the reference clock.
`timescale 1ns/1ps
module mor_checker (
   // Clocks and reset.
   input wire logic i_ref_clk,
   input wire logic i_link_clk,
   input wire logic i_rst_b,
   // Link request port.
   input wire logic i_req_valid,
   input wire logic o_req_ready,
   input wire logic o_rsp_valid,
   input wire logic [7:0] o_rsp_data,
   // Event and sync side.
   input wire logic i_mag_done,
   input wire logic [9:0] o_sync_period,
   input wire logic o_sync_tick,
   input wire logic o_ibi_request
);
   // A request is taken, then answered within a bounded wait.
   sequence s_take;
      i_req_valid && o_req_ready;
   endsequence
   sequence s_answer;
      ##[2:10] o_rsp_valid;
   endsequence
   // Link handshake checks.
   ready_drop_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
      s_take |=> !o_req_ready) else $error("Ready stayed high after a take.");
   req_answer_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
      s_take |-> s_answer) else $error("Request was not answered in time.");
   rsp_pulse_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
      o_rsp_valid |=> !o_rsp_valid) else $error("Response lasted over one cycle.");
   rsp_hold_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
      $changed(o_rsp_data) |-> o_rsp_valid) else $error("Read data moved without a response.");
   ready_back_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
      $rose(o_req_ready) |-> o_rsp_valid) else $error("Ready returned without a response.");
   // Event side checks.
   tick_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      o_sync_tick |=> !o_sync_tick) else $error("Sync tick lasted over one cycle.");
   ibi_raise_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      i_mag_done |-> ##[1:3] o_ibi_request) else $error("No interrupt request after a result.");
   period_even_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      o_sync_period[0] == 1'b0) else $error("Sync period bit 0 is set.");
endmodule
bind mor_regs mor_checker u_chk (.i_ref_clk, .i_link_clk, .i_rst_b, .i_req_valid, .o_req_ready,
   .o_rsp_valid, .o_rsp_data, .i_mag_done, .o_sync_period, .o_sync_tick, .o_ibi_request);

// file: tb/mor_host.sv
// Purpose: Bus engine model that issues requests on the link port.
// Assumes: One request outstanding; the block answers within a few link cycles.
// Notes: Released address, data and i2c lines show the inverse of their last value.
`timescale 1ns/1ps
module mor_host (
   // Link clock.
   input wire logic i_link_clk,
   // Request side.
   output logic o_req_valid,
   output logic [2:0] o_req_kind,
   output logic [7:0] o_req_addr,
   output logic [7:0] o_req_data,
   output logic o_req_i2c,
   // Answer side.
   input wire logic i_req_ready,
   input wire logic i_rsp_valid,
   input wire logic [7:0] i_rsp_data
);
   initial begin
      o_req_valid = 1'b0;
      o_req_kind = 3'h0;
      o_req_addr = 8'h00;
      o_req_data = 8'h00;
      o_req_i2c = 1'b0;
   end
   // Offer one request, hold it until taken, then wait for its answer.
   task automatic req(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d,
         input logic i2c, output logic [7:0] rd, output logic ok);
      int n;
      n = 0;
      @(posedge i_link_clk);
      #1;
      o_req_valid = 1'b1;
      o_req_kind = k;
      o_req_addr = a;
      o_req_data = (k == 3'h1 && a == 8'h0B) ? {6'h00, d[1:0]} : d;
      o_req_i2c = i2c;
      while (!i_req_ready && n < 20) begin
         @(negedge i_link_clk);
         n++;
      end
      @(posedge i_link_clk);
      #1;
      o_req_valid = 1'b0;
      o_req_addr = ~o_req_addr;
      o_req_data = ~o_req_data;
      o_req_i2c = ~o_req_i2c;
      n = 0;
      do begin
         @(negedge i_link_clk);
         n++;
      end while (!i_rsp_valid && n < 20);
      rd = i_rsp_data;
      ok = i_rsp_valid;
   endtask
endmodule

// file: tb/tb_magnetometer_output_status_regs.sv
// Purpose: Self-checking bench for the magnetometer output and status registers.
// Assumes: The host model issues link requests; the bench drives measurement events.
// Notes: Expected values come from a small model of fields and flags.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_magnetometer_output_status_regs;
   import mor_pkg::*;
   logic rclk = 1'b0, lclk = 1'b0, rst_b = 1'b0, via_i2c = 1'b0, stf = 1'b0;
   logic valid, i2c, ready, rspv, tick, ibi;
   logic [2:0] kind;
   logic [7:0] addr, data, rspd, tmp = 8'h00, st = 8'h00;
   logic [1:0] res_mode = 2'h0, tu;
   logic [6:0] ev = 7'h00;
   logic [19:0] fld [3];
   logic [9:0] period;
   logic [31:0] seed = 32'h95B4EDD8;
   int err_count = 0, checks = 0, cyc = 0, nt = 0;
   // Clocks, unrelated in phase.
   initial begin
      forever #2 rclk = ~rclk;
   end
   initial begin
      #7;
      forever #40 lclk = ~lclk;
   end
   mor_regs DUT (.i_ref_clk(rclk), .i_rst_b(rst_b), .i_link_clk(lclk), .i_req_valid(valid),
      .i_req_kind(kind), .i_req_addr(addr), .i_req_data(data), .i_req_i2c(i2c),
      .o_req_ready(ready), .o_rsp_valid(rspv), .o_rsp_data(rspd), .i_res_mode(res_mode),
      .i_mag_done(ev[0]), .i_mag_x(fld[0]), .i_mag_y(fld[1]), .i_mag_z(fld[2]),
      .i_temp_done(ev[1]), .i_temp(tmp), .i_meas_cmd(ev[2]), .i_start_motion(ev[3]),
      .i_motion(ev[4]), .i_mem_load_start(ev[5]), .i_mem_load_ok(ev[6]),
      .i_selftest_fail(stf), .o_sync_period(period), .o_sync_time_unit(tu),
      .o_sync_tick(tick), .o_ibi_request(ibi));
   mor_host u_host (.i_link_clk(lclk), .o_req_valid(valid), .o_req_kind(kind),
      .o_req_addr(addr), .o_req_data(data), .o_req_i2c(i2c), .i_req_ready(ready),
      .i_rsp_valid(rspv), .i_rsp_data(rspd));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic report_and_stop;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Cycle limit and sync tick counter.
   always @(negedge rclk) begin
      cyc++;
      if (tick === 1'b1) nt++;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   // One-cycle event pulse on the reference clock.
   task automatic pulse(input int b);
      @(posedge rclk);
      #1 ev[b] = 1'b1;
      @(posedge rclk);
      #1 ev = 7'h00;
      repeat (4) @(posedge rclk);
      #1;
   endtask
   // One link request; the answer byte is compared and the flag model updated.
   task automatic acc(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d,
         input logic [7:0] e);
      logic [7:0] v;
      logic ok;
      u_host.req(k, a, d, via_i2c, v, ok);
      `CHK("answer", 1'b1, ok)
      `CHK("rsp_data", e, v)
      if (k <= 3'h1 && a <= 8'h08) st &= ~{1'b0, k == 3'h0, 5'h00, via_i2c};
      if (k <= 3'h1 && a == 8'h09) st &= ~{k == 3'h0, 5'h00, via_i2c, 1'b0};
      if (k == 3'h0 && a == 8'h18) st &= 8'hF8;
      if (k == 3'h4) st |= 8'h08;
      if (k == 3'h5) st &= 8'hF0;
      repeat (3) @(posedge rclk);
      #1;
   endtask
   initial begin
      logic [7:0] lo, hi, d, e;
      logic [19:0] m;
      int ax;
      fld = '{20'h00000, 20'h00000, 20'h00000};
      repeat (2) @(posedge lclk);
      @(posedge rclk);
      #1 rst_b = 1'b1;
      // Status, write-only and unmapped places read zero after reset.
      foreach (fld[i]) acc(3'h0, 8'h0A + i[7:0], 8'h00, 8'h00);
      acc(3'h0, 8'h30, 8'h00, 8'h00);
      acc(3'h0, 8'h18, 8'h00, st);
      // Field results in each resolution, via both bus kinds.
      for (int r = 0; r < 4; r++) begin
         via_i2c = r[0];
         res_mode = r[1:0];
         foreach (fld[i]) begin
            seed = lfsr_next(seed);
            fld[i] = seed[19:0];
         end
         m = (r == 0) ? 20'hFFFF0 : (r == 1) ? 20'hFFFFC : 20'hFFFFF;
         pulse(0);
         st |= 8'h41;
         acc(3'h1, 8'h00, seed[27:20], 8'h00);
         acc(3'h0, 8'h18, 8'h00, st);
         for (int a = 0; a < 9; a++) begin
            ax = (a < 6) ? a / 2 : a - 6;
            e = (a >= 6) ? {fld[ax][3:0] & m[3:0], 4'h0} :
               (a % 2 == 1) ? fld[ax][11:4] : fld[ax][19:12];
            acc(3'h0, a[7:0], 8'h00, e);
         end
         acc(3'h0, 8'h18, 8'h00, st);
      end
      // Temperature result and measurement command clears.
      via_i2c = 1'b0;
      tmp = seed[7:0];
      pulse(1);
      st |= 8'h82;
      acc(3'h0, 8'h09, 8'h00, tmp);
      via_i2c = 1'b1;
      acc(3'h1, 8'h09, tmp, 8'h00);
      via_i2c = 1'b0;
      acc(3'h0, 8'h18, 8'h00, st);
      pulse(0);
      pulse(1);
      st |= 8'hC3;
      pulse(2);
      st &= 8'hFC;
      acc(3'h0, 8'h18, 8'h00, st);
      // Sync period by register and by command, both widths.
      for (int i = 0; i < 4; i++) begin
         seed = lfsr_next(seed);
         lo = {i[1], seed[6:0]};
         hi = {6'h00, seed[9:8]};
         acc(3'h1, 8'h0B, hi, 8'h00);
         if (i[0]) acc(3'h2, 8'h3F, lo, 8'h00);
         else acc(3'h1, 8'h0A, lo, 8'h00);
         `CHK("period", {lo[7] ? hi[1:0] : 2'h0, lo[6:0], 1'b0}, period)
         d = seed[17:10];
         if (i[0]) acc(3'h2, 8'h9F, d, 8'h00);
         else acc(3'h1, 8'h0C, d, 8'h00);
         acc(3'h2, 8'h8F, ~d, 8'h00);
         `CHK("time_unit", d[1:0], tu)
      end
      // Sync tick request.
      nt = 0;
      acc(3'h3, 8'h00, 8'h00, 8'h00);
      `CHK("ticks", 1, nt)
      // Parity failure raises the interrupt request until it is sent.
      acc(3'h4, 8'h00, 8'h00, 8'h00);
      `CHK("ibi", 1'b1, ibi)
      acc(3'h6, 8'h18, 8'hFF, 8'h00);
      acc(3'h0, 8'h18, 8'h00, st);
      acc(3'h5, 8'h00, 8'h00, 8'h00);
      `CHK("ibi", 1'b0, ibi)
      // Motion, memory load and self-test flags.
      pulse(4);
      st |= 8'h04;
      pulse(3);
      st &= 8'hFB;
      acc(3'h0, 8'h18, 8'h00, st);
      pulse(4);
      st |= 8'h04;
      acc(3'h5, 8'h00, 8'h00, 8'h00);
      pulse(6);
      st |= 8'h10;
      stf = 1'b1;
      st[5] = 1'b1;
      acc(3'h0, 8'h18, 8'h00, st);
      pulse(5);
      st &= 8'hEF;
      stf = 1'b0;
      st[5] = 1'b0;
      acc(3'h0, 8'h18, 8'h00, st);
      report_and_stop();
   end
endmodule
